/* hdl/asc_pkg.sv */
// Constants and types of the converter scan sequencer
// --------------------
// How it works
// RULE1: Software trigger set starts an internal scan at chip select rise.
// RULE2: Host holds chip select low 17 clocks when setting software trigger.
// RULE3: Software trigger clears itself when the scan completes.
// RULE4: Host waits for end of conversion low before the next frame.
// RULE5: Echo enabled config write is returned on data out next frame.
// RULE6: Manual mode converts the commanded channel, result next frame.
// RULE7: Repeat mode converts one channel the programmed count into FIFO.
// RULE8: List modes convert flagged channels of both list registers ascending.
// RULE9: Scan modes step the multiplexer on the thirteenth falling clock edge.
// RULE10: Ascending-from-zero converts channels 0 up to the channel field.
// RULE11: Ascending-to-top converts channel field up to the highest channel.
// RULE12: User sequence holds up to 256 entries, external clock only.
// RULE13: User sequence repeats until replaced, reloadable any time.
// RULE14: Averaging stores only the mean of the programmed conversions.
// RULE15: Paired channels are still visited per channel number.
// RULE16: Command bit 15 low writes the mode control register.
// RULE17: Bit 15 high: bits 14:11 pick the register, bits 10:0 data.
// RULE18: Host never sends bits 15:11 all ones.
// RULE19: Scan field is bits 14:11, reset value 0001.
// RULE20: Channel field is bits 10:7, reset value 0000.
// RULE21: Reset field: 01 clears FIFO, 10 restores all and FIFO.
// RULE22: Scan code 0000 keeps the mode; only bits 6:3 and 1 apply. The code also applies bit 2 (chan_id).
// RULE23: Software trigger is mode bit 1, reset 0, internal clock only.
// RULE24: Frame spans chip select falls; sample rising, shift falling.
// RULE25: FIFO holds 16 results; when full newest overwrites oldest.
// RULE26: Command applies after the sixteenth rising serial clock edge.
// RULE27: Modes under the wrong clocking are not rejected.
// --------------------
package asc_pkg;
  localparam int CMD_EDGE = 16;
  localparam int MUX_EDGE = 13;
  localparam int RES_W = 12;
  localparam int CH_W = 4;
  localparam int NUM_CH = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int SEQ_DEPTH = 256;
  localparam logic [3:0] SC_NULL = 4'h0, SC_MAN = 4'h1, SC_REP = 4'h2, SC_STD_I = 4'h3,
    SC_STD_E = 4'h4, SC_UP_I = 4'h5, SC_UP_E = 4'h6, SC_LST_I = 4'h7, SC_LST_E = 4'h8,
    SC_USEQ = 4'h9;
  localparam logic [3:0] SEL_CFG = 4'h0, SEL_UNI = 4'h1, SEL_BIP = 4'h2, SEL_RNG = 4'h3,
    SEL_LS0 = 4'h4, SEL_LS1 = 4'h5, SEL_USEQ = 4'h6;
  localparam logic [1:0] RST_FIFO = 2'h1, RST_ALL = 2'h2;
  localparam logic [3:0] SCAN_RST = 4'h1, CHSEL_RST = 4'h0;
  localparam logic [10:0] REG_RST = 11'h000;
  localparam int CFG_ECHO = 2, CFG_NREP = 5, CFG_AVG_N = 7, CFG_AVG_EN = 9, SEQ_NEW = 10;
  typedef struct packed {
    logic        cls;
    logic [3:0]  sel;
    logic [10:0] data;
  } asc_cmd_t;
  typedef struct packed {
    logic [3:0] scan;
    logic [3:0] ch;
    logic [1:0] rst;
    logic [1:0] pm;
    logic       chan_id;
    logic       software_convert_trigger;
    logic       spare;
  } asc_mode_t;
  typedef struct packed {
    logic [CH_W-1:0]  ch;
    logic [RES_W-1:0] val;
  } asc_res_t;
  typedef enum logic [1:0] {ST_IDLE, ST_GO, ST_WAIT, ST_DONE} asc_state_t;
endpackage

/* hdl/asc_top.sv */
// Scan sequencer: serial link, command decode, scan control, result FIFO
`timescale 1ns/1ps
module asc_top
  import asc_pkg::*;
#(
  parameter int NCH  = NUM_CH,
  parameter int FDEP = FIFO_DEPTH,
  parameter int SDEP = SEQ_DEPTH
) (
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic             SCLK,
  input  wire logic             CS_N,
  input  wire logic             DIN,
  output logic                  DOUT,
  input  wire logic             CONVERT_START_PIN_N,
  output logic                  EOC_N,
  output logic [CH_W-1:0]       MUX_CH,
  output logic                  CONV_GO,
  input  wire logic             CONV_DONE,
  input  wire logic [RES_W-1:0] CONV_DATA,
  output logic [10:0]           UNIPOLAR_CFG,
  output logic [10:0]           BIPOLAR_CFG,
  output logic [10:0]           RANGE_CFG,
  output logic [1:0]            POWER_MODE
);
  localparam int FW = $clog2(FDEP);
  localparam int SW = $clog2(SDEP);

  if (!(NCH inside {4, 8, 12, 16}) || FDEP < 2 || (1 << FW) != FDEP
      || SDEP < 2 || SDEP > 256 || (1 << SW) != SDEP) begin : g_bad
    $error("asc_top: unsupported parameter");
  end

  // --------------------
  // Link side, serial clock domain
  // --------------------
  logic [4:0]  rcnt;
  logic [4:0]  fcnt;
  logic [14:0] rx_sh;
  logic [15:0] tx_sh;
  logic [15:0] tx_word;
  asc_cmd_t    cmd_word;
  logic        cmd_tgl;
  logic        mux_tgl;

  always_ff @(posedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      rcnt  <= '0;
      rx_sh <= '0;
    end else begin
      rx_sh <= {rx_sh[13:0], DIN}; // RULE24
      if (rcnt != 5'(CMD_EDGE)) rcnt <= rcnt + 5'h1;
    end
  end

  // Word and toggle outlive the frame, so chip select does not clear them
  always_ff @(posedge SCLK or negedge NRST) begin
    if (!NRST) begin
      cmd_word <= '0;
      cmd_tgl  <= 1'b0;
    end else if (!CS_N && rcnt == 5'(CMD_EDGE - 1)) begin
      cmd_word <= {rx_sh, DIN}; // RULE26
      cmd_tgl  <= ~cmd_tgl;
    end
  end

  // tx_word changes only on a synced chip select rise or a reset, so it is still here
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      fcnt  <= '0;
      tx_sh <= '0;
    end else begin
      if (fcnt != 5'h1F) fcnt <= fcnt + 5'h1;
      tx_sh <= (fcnt == 5'h0) ? tx_word : {tx_sh[14:0], 1'b0}; // RULE24
    end
  end

  always_ff @(negedge SCLK or negedge NRST) begin
    if (!NRST) mux_tgl <= 1'b0;
    else if (!CS_N && fcnt == 5'(MUX_EDGE - 1)) mux_tgl <= ~mux_tgl; // RULE9
  end

  assign DOUT = tx_sh[15];

  // --------------------
  // Crossings into the system clock domain
  // --------------------
  logic [2:0] cs_s;
  logic [2:0] cv_s;
  logic [2:0] ct_s;
  logic [2:0] mt_s;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      cs_s <= 3'h7;
      cv_s <= 3'h7;
      ct_s <= 3'h0;
      mt_s <= 3'h0;
    end else begin
      cs_s <= {cs_s[1:0], CS_N};
      cv_s <= {cv_s[1:0], CONVERT_START_PIN_N};
      ct_s <= {ct_s[1:0], cmd_tgl};
      mt_s <= {mt_s[1:0], mux_tgl};
    end
  end

  wire cs_rise = cs_s[1] & ~cs_s[2];
  wire cs_fall = ~cs_s[1] & cs_s[2];
  wire cv_fall = ~cv_s[1] & cv_s[2];
  wire cmd_stb = ct_s[1] ^ ct_s[2];
  wire mux_stb = mt_s[1] ^ mt_s[2];

  // --------------------
  // Command decode and registers
  // --------------------
  asc_mode_t   mw;
  logic [3:0]  scan;
  logic [3:0]  chsel;
  logic        chan_id;
  logic        sw;
  logic [10:0] cfg;
  logic [10:0] ls0;
  logic [10:0] ls1;
  logic        echo_pend;
  asc_state_t  st;

  assign mw = asc_mode_t'({cmd_word.sel, cmd_word.data});
  wire mode_wr = cmd_stb & ~cmd_word.cls; // RULE16
  wire reg_wr  = cmd_stb & cmd_word.cls; // RULE17
  wire rst_all = mode_wr && mw.rst == RST_ALL; // RULE21
  wire rst_ff  = mode_wr && (mw.rst == RST_FIFO || mw.rst == RST_ALL); // RULE21
  wire man_wr  = mode_wr && mw.scan == SC_MAN;
  wire int_mode = scan inside {SC_REP, SC_STD_I, SC_UP_I, SC_LST_I};
  wire [15:0] lmask = {ls0[7:0], ls1[7:0]};

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) begin
      scan       <= SCAN_RST; // RULE19
      chsel      <= CHSEL_RST; // RULE20
      POWER_MODE <= '0;
      chan_id    <= 1'b0;
      sw         <= 1'b0;
    end else begin
      if (mode_wr) begin
        POWER_MODE <= mw.pm; // RULE22
        chan_id    <= mw.chan_id;
      end
      if (mode_wr && mw.scan != SC_NULL) begin // RULE22
        scan  <= mw.scan;
        chsel <= mw.ch;
      end
      if (mode_wr && mw.software_convert_trigger) sw <= 1'b1; // RULE23
      else if (st == ST_DONE) sw <= 1'b0; // RULE3
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) begin
      cfg          <= REG_RST;
      UNIPOLAR_CFG <= REG_RST;
      BIPOLAR_CFG  <= REG_RST;
      RANGE_CFG    <= REG_RST;
      ls0          <= REG_RST;
      ls1          <= REG_RST;
    end else if (reg_wr) begin
      case (cmd_word.sel) // RULE17
        SEL_CFG: cfg          <= cmd_word.data;
        SEL_UNI: UNIPOLAR_CFG <= cmd_word.data;
        SEL_BIP: BIPOLAR_CFG  <= cmd_word.data;
        SEL_RNG: RANGE_CFG    <= cmd_word.data;
        SEL_LS0: ls0          <= cmd_word.data;
        SEL_LS1: ls1          <= cmd_word.data;
        default: ;
      endcase
    end
  end

  wire cfg_wr = reg_wr && cmd_word.sel == SEL_CFG;

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) echo_pend <= 1'b0;
    else if (cfg_wr) echo_pend <= cmd_word.data[CFG_ECHO]; // RULE5
    else if (cs_rise) echo_pend <= 1'b0;
  end

  // --------------------
  // User sequence store
  // --------------------
  logic [CH_W-1:0] seq_mem [SDEP];
  logic [SW:0]     seq_len;
  logic [SW-1:0]   seq_rp;
  wire seq_wr  = reg_wr && cmd_word.sel == SEL_USEQ;
  wire seq_new = cmd_word.data[SEQ_NEW] || seq_len == (SW+1)'(SDEP);
  wire [SW-1:0] seq_wp = seq_new ? '0 : seq_len[SW-1:0];
  wire [SW:0] seq_nrp = (SW+1)'(seq_rp) + 1'b1;

  always_ff @(posedge CLK) begin
    if (seq_wr) seq_mem[seq_wp] <= cmd_word.data[CH_W-1:0]; // RULE12
  end

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) begin
      seq_len <= '0;
      seq_rp  <= '0;
    end else if (seq_wr) begin
      seq_len <= (SW+1)'(seq_wp) + 1'b1; // RULE13
      if (seq_new) seq_rp <= '0;
    end else if (mux_stb && scan == SC_USEQ && seq_len != '0) begin
      seq_rp <= (seq_nrp >= seq_len) ? '0 : seq_nrp[SW-1:0]; // RULE13
    end
  end

  // --------------------
  // Channel set of the scan modes
  // --------------------
  // Mode state comes in as arguments so the continuous assignments track it
  function automatic logic in_set(input logic [4:0]  c,
                                  input logic [3:0]  sc,
                                  input logic [3:0]  bnd,
                                  input logic [15:0] m);
    logic r;
    r = 1'b0;
    if (c <= 5'(NCH - 1)) begin
      case (sc)
        SC_STD_I, SC_STD_E: r = c <= {1'b0, bnd}; // RULE10
        SC_UP_I, SC_UP_E:   r = c >= {1'b0, bnd}; // RULE11
        SC_LST_I, SC_LST_E: r = m[c[3:0]]; // RULE8
        default:            r = c == {1'b0, bnd};
      endcase
    end
    return r;
  endfunction

  // Lowest member at or above s; bit 4 flags a hit
  function automatic logic [4:0] first_from(input logic [4:0]  s,
                                            input logic [3:0]  sc,
                                            input logic [3:0]  bnd,
                                            input logic [15:0] m);
    logic [4:0] r;
    logic [4:0] c;
    r = 5'h0;
    for (int i = 15; i >= 0; i--) begin
      c = s + 5'(i);
      if (in_set(c, sc, bnd, m)) r = {1'b1, c[3:0]}; // RULE15
    end
    return r;
  endfunction

  logic [CH_W-1:0] cur;
  wire [4:0] first = first_from(5'h0, scan, chsel, lmask);
  wire [4:0] after = first_from(5'(cur) + 5'h1, scan, chsel, lmask);
  wire [4:0] ext_a = first_from(5'(MUX_CH) + 5'h1, scan, chsel, lmask);
  wire [CH_W-1:0] ext_next = (scan == SC_USEQ) ? seq_mem[seq_rp]
                           : (ext_a[4] ? ext_a[3:0] : first[3:0]);

  // --------------------
  // Internally clocked scan
  // --------------------
  logic [4:0]       rep_left;
  logic [5:0]       avg_left;
  logic [RES_W+4:0] sum;
  wire [2:0] ash = cfg[CFG_AVG_EN] ? 3'(cfg[CFG_AVG_N +: 2]) + 3'h2 : 3'h0;
  wire [5:0] avg_n = 6'(1) << ash;
  wire [4:0] rep_n = {1'b0, cfg[CFG_NREP +: 2], 2'h0} + 5'h4;
  wire sw_go = sw & cs_rise; // RULE1
  wire start = (cv_fall | sw_go) & int_mode & st == ST_IDLE; // RULE27
  wire last_avg = avg_left <= 6'h1;
  wire push = st == ST_WAIT & CONV_DONE & last_avg;
  wire [RES_W+4:0] tot = sum + (RES_W+5)'(CONV_DATA);
  wire [RES_W+4:0] avg_val = tot >> ash; // RULE14

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) begin
      st       <= ST_IDLE;
      cur      <= '0;
      rep_left <= '0;
      avg_left <= '0;
      sum      <= '0;
    end else begin
      unique case (st)
        ST_IDLE: if (start) begin
          cur      <= (scan == SC_REP) ? chsel : first[3:0];
          rep_left <= rep_n;
          avg_left <= avg_n;
          sum      <= '0;
          st       <= (scan == SC_REP || first[4]) ? ST_GO : ST_DONE;
        end
        ST_GO: st <= ST_WAIT;
        ST_WAIT: if (CONV_DONE) begin
          if (!last_avg) begin
            avg_left <= avg_left - 6'h1; // RULE14
            sum      <= tot;
            st       <= ST_GO;
          end else begin
            avg_left <= avg_n;
            sum      <= '0;
            if (scan == SC_REP && rep_left > 5'h1) begin
              rep_left <= rep_left - 5'h1; // RULE7
              st       <= ST_GO;
            end else if (scan != SC_REP && after[4]) begin
              cur <= after[3:0]; // RULE10 RULE11 RULE8
              st  <= ST_GO;
            end else begin
              st <= ST_DONE;
            end
          end
        end
        ST_DONE: st <= ST_IDLE;
      endcase
    end
  end

  // --------------------
  // Result FIFO
  // --------------------
  asc_res_t   fmem [FDEP];
  logic [FW-1:0] wp;
  logic [FW-1:0] rp;
  logic [FW:0]   cnt;
  wire full = cnt == (FW+1)'(FDEP);
  wire pop  = cs_rise & ~echo_pend & int_mode & cnt != '0;
  wire drop = push & full & ~pop; // RULE25

  always_ff @(posedge CLK) begin
    if (push) fmem[wp] <= '{ch: cur, val: avg_val[RES_W-1:0]};
  end

  always_ff @(posedge CLK) begin
    if (!NRST || rst_ff) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop || drop) rp <= rp + 1'b1; // RULE25
      if (push && !pop && !full) cnt <= cnt + 1'b1;
      else if (pop && !push) cnt <= cnt - 1'b1;
    end
  end

  // --------------------
  // Externally clocked conversions and outputs
  // --------------------
  asc_res_t ext_res;
  logic     man_d;
  wire ext_auto = ~int_mode & scan != SC_MAN;
  wire [15:0] ext_word = chan_id ? 16'(ext_res) : {1'b0, ext_res.val, 3'h0};
  wire [15:0] next_tx = echo_pend ? {5'h0, cfg}
                      : int_mode ? (cnt != '0 ? 16'(fmem[rp]) : 16'h0) : ext_word;

  always_ff @(posedge CLK) begin
    if (!NRST || rst_all) begin
      MUX_CH  <= '0;
      CONV_GO <= 1'b0;
      man_d   <= 1'b0;
      ext_res <= '0;
      tx_word <= '0;
      EOC_N   <= 1'b1;
    end else begin
      man_d   <= man_wr;
      CONV_GO <= st == ST_GO | (cs_fall & ext_auto) | man_d;
      if (int_mode) MUX_CH <= cur;
      else if (man_wr) MUX_CH <= mw.ch; // RULE6
      else if (mux_stb && scan != SC_MAN) MUX_CH <= ext_next; // RULE9
      if (CONV_DONE && !int_mode) ext_res <= '{ch: MUX_CH, val: CONV_DATA};
      if (cs_rise) tx_word <= next_tx; // RULE5 RULE6
      if (st == ST_DONE) EOC_N <= 1'b0;
      else if (cs_fall || cv_fall) EOC_N <= 1'b1;
    end
  end

  // --------------------
  // Checks
  // --------------------
  sequence s_man;
    (MUX_CH == mw.ch) ##1 CONV_GO;
  endsequence

  AST_SW_START: // RULE1
    assert property (@(posedge CLK) disable iff (!NRST)
      (sw && cs_rise && int_mode && st == ST_IDLE) |=> st != ST_IDLE)
    else $error("software trigger did not start a scan");
  AST_SW_CLEAR: // RULE3
    assert property (@(posedge CLK) disable iff (!NRST)
      (st == ST_DONE && !(mode_wr && mw.software_convert_trigger)) |=> !sw ##0 !EOC_N)
    else $error("trigger not cleared at scan end");
  AST_ECHO: // RULE5
    assert property (@(posedge CLK) disable iff (!NRST)
      (echo_pend && cs_rise && !rst_all) |=> tx_word == {5'h0, $past(cfg)})
    else $error("config word not echoed");
  AST_MANUAL: // RULE6
    assert property (@(posedge CLK) disable iff (!NRST)
      (man_wr && !rst_all && !int_mode) |=> s_man)
    else $error("manual channel not converted");
  AST_OVERWRITE: // RULE25
    assert property (@(posedge CLK) disable iff (!NRST)
      (drop && !rst_ff) |=> cnt == (FW+1)'(FDEP) && rp != $past(rp))
    else $error("full FIFO did not drop oldest");
  AST_RESET_ALL: // RULE21
    assert property (@(posedge CLK) disable iff (!NRST)
      rst_all |=> scan == SCAN_RST && chsel == CHSEL_RST && cnt == '0 && st == ST_IDLE)
    else $error("register reset incomplete");
  AST_NULL_KEEP: // RULE22
    assert property (@(posedge CLK) disable iff (!NRST)
      (mode_wr && mw.scan == SC_NULL && !rst_all) |=> $stable(scan) && $stable(chsel))
    else $error("null scan code changed the mode");
  AST_CMD16: // RULE26
    assert property (@(posedge SCLK) disable iff (!NRST || CS_N)
      rcnt == 5'(CMD_EDGE - 1) |=> cmd_word[0] == $past(DIN) && cmd_tgl != $past(cmd_tgl))
    else $error("command word not taken at edge sixteen");
  AST_MUX13: // RULE9
    assert property (@(negedge SCLK) disable iff (!NRST || CS_N)
      fcnt == 5'(MUX_EDGE - 1) |=> mux_tgl != $past(mux_tgl))
    else $error("multiplexer step missed");
endmodule // asc_top

/* tb/asc_host.sv */
// Host serial master model driving the scan sequencer link
`timescale 1ns/1ps
module asc_host (
  output logic      SCLK,
  output logic      CS_N,
  output logic      DIN,
  input  wire logic DOUT
);
  initial begin
    SCLK = 1'b1;
    DIN  = 1'b1;
    // A late rise gives the link counters a clearing edge
    #1 CS_N = 1'b1;
  end
  // ----------------------------------------
  // One frame: n clocks, word MSB first
  // ----------------------------------------
  // Clock idles high and stands still between frames
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0;
    #37 CS_N = 1'b0;
    #80;
    for (int i = 0; i < n; i++) begin
      SCLK = 1'b0;
      DIN = (i < 16) ? w[15-i] : 1'b0;
      #80 SCLK = 1'b1;
      if (i < 16) r = {r[14:0], DOUT};
      #80;
    end
    CS_N = 1'b1;
    // Released line shows no stale bit
    DIN = ~DIN;
    #400;
  endtask
endmodule // asc_host

/* tb/test_adc_scan_sequencer_control.sv */
// Self-checking bench of the converter scan sequencer
`timescale 1ns/1ps
module test_adc_scan_sequencer_control;
  import asc_pkg::*;
  logic             CLK = 1'b0;
  logic             NRST = 1'b1;
  logic             PIN_N = 1'b1;
  logic             CONV_DONE = 1'b0;
  logic [RES_W-1:0] CONV_DATA = '0;
  logic             SCLK, CS_N, DIN, DOUT, EOC_N, CONV_GO;
  logic [CH_W-1:0]  MUX_CH, gch;
  logic [10:0]      UNI, BIP, RNG;
  logic [1:0]       PM;
  logic [15:0]      r;
  logic [CH_W-1:0]  chq[$];
  int               err_count = 0;
  int               check_count = 0;
  int               cnt = 0;
  int               dly = 0;

  always #25 CLK = ~CLK;

  asc_top DUT (.CLK(CLK), .NRST(NRST), .SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT),
    .CONVERT_START_PIN_N(PIN_N), .EOC_N(EOC_N), .MUX_CH(MUX_CH), .CONV_GO(CONV_GO),
    .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .UNIPOLAR_CFG(UNI), .BIPOLAR_CFG(BIP),
    .RANGE_CFG(RNG), .POWER_MODE(PM));
  asc_host HOST (.SCLK(SCLK), .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT));

  // ----------------------------------------
  // Converter core stand-in
  // ----------------------------------------
  // Data carries channel and sample index so order and averaging show
  always @(posedge CLK) begin
    #1 CONV_DONE = 1'b0;
    if (CONV_GO === 1'b1) begin
      chq.push_back(MUX_CH);
      gch = MUX_CH;
      dly = 4;
    end else if (dly > 0) begin
      dly--;
      if (dly == 0) begin
        CONV_DONE = 1'b1;
        CONV_DATA = {gch, cnt[7:0]};
        cnt++;
      end
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task conclude;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task chkq(input int e[$]);
    chk(16'(chq.size()), 16'(e.size()));
    if (chq.size() == e.size())
      foreach (e[i]) chk({12'h0, chq[i]}, 16'(e[i]));
  endtask
  function automatic logic [15:0] mw(logic [3:0] sc, logic [3:0] c, logic [1:0] rs,
                                     logic [1:0] p, logic sw);
    asc_mode_t m;
    m = '{scan: sc, ch: c, rst: rs, pm: p, chan_id: 1'b1, software_convert_trigger: sw, spare: 1'b0};
    return {1'b0, m};
  endfunction
  // Select code never 4'hF
  function automatic logic [15:0] rw(logic [3:0] s, logic [10:0] d);
    return asc_cmd_t'{cls: 1'b1, sel: s, data: d};
  endfunction
  task go(input logic [15:0] w, input int n = 16);
    HOST.xfer(w, n, r);
  endtask
  task wait_eoc;
    repeat (3000) if (EOC_N !== 1'b0) @(posedge CLK);
    chk({15'h0, EOC_N}, 16'h0);
  endtask
  task t_scan(input logic [3:0] sc, input logic [3:0] c, input int e[$]);
    cnt = 0;
    chq.delete();
    go(mw(sc, c, RST_FIFO, 2'h0, 1'b0));
    @(posedge CLK);
    #1 PIN_N = 1'b0;
    repeat (2) @(posedge CLK);
    #1 PIN_N = 1'b1;
    wait_eoc;
    chkq(e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    chk({EOC_N, CONV_GO, MUX_CH, PM, 8'h0}, 16'h8000);
    chk({5'h0, UNI}, 16'h0);
  endtask
  task t_regs;
    go(rw(SEL_UNI, 11'h555));
    go(rw(SEL_BIP, 11'h2AA));
    go(rw(SEL_RNG, 11'h123));
    go(rw(4'h7, 11'h7FF));
    go(rw(SEL_UNI, 11'h000), 15);
    chk({5'h0, UNI}, 16'h0555);
    chk({5'h0, BIP}, 16'h02AA);
    chk({5'h0, RNG}, 16'h0123);
    go(mw(SC_NULL, 4'hF, 2'h0, 2'h3, 1'b0));
    chk({14'h0, PM}, 16'h0003);
  endtask
  task t_echo;
    go(rw(SEL_CFG, 11'h004));
    go(16'h0);
    chk(r, 16'h0004);
  endtask
  task t_repeat;
    cnt = 0;
    chq.delete();
    go(mw(SC_REP, 4'h5, RST_FIFO, 2'h0, 1'b1), 17);
    wait_eoc;
    chkq('{5, 5, 5, 5});
    chq.delete();
    go(16'h0, 8);
    repeat (40) @(posedge CLK);
    chk(16'(chq.size()), 16'h0);
    for (int i = 0; i < 4; i++) begin
      go(16'h0);
      chk(r, {8'h55, 8'(i)});
    end
    go(16'h0);
    chk(r, 16'h0);
  endtask
  task t_avg;
    go(rw(SEL_CFG, 11'h200));
    t_scan(SC_STD_I, 4'h0, '{0, 0, 0, 0});
    go(16'h0);
    go(16'h0);
    chk(r, 16'h0001);
  endtask
  task t_rstall;
    go(rw(SEL_UNI, 11'h555));
    go(mw(SC_NULL, 4'h0, RST_ALL, 2'h0, 1'b0));
    chk({5'h0, UNI}, 16'h0);
  endtask

  task t_ovf;
    go(rw(SEL_CFG, 11'h060));
    cnt = 0;
    go(mw(SC_REP, 4'h3, RST_FIFO, 2'h0, 1'b0));
    repeat (2) begin
      @(posedge CLK);
      #1 PIN_N = 1'b0;
      repeat (2) @(posedge CLK);
      #1 PIN_N = 1'b1;
      // Let the pin fall lift the end-of-conversion flag of the last scan
      repeat (2) @(posedge CLK);
      wait_eoc;
    end
    chk(16'(cnt), 16'h0020);
    go(16'h0);
    go(16'h0);
    chk(r, 16'h3310);
  endtask
  task t_man;
    chq.delete();
    go(mw(SC_MAN, 4'h6, 2'h0, 2'h0, 1'b0));
    repeat (4) @(posedge CLK);
    chk({12'h0, MUX_CH}, 16'h0006);
    chkq('{6});
  endtask

  initial begin
    #3000000;
    err_count++;
    conclude;
  end
  initial begin
    // Falling edge clears the link-side toggles
    #1 NRST = 1'b0;
    repeat (4) @(posedge CLK);
    #1 NRST = 1'b1;
    repeat (4) @(posedge CLK);
    t_reset;
    t_regs;
    t_echo;
    t_repeat;
    t_scan(SC_STD_I, 4'h2, '{0, 1, 2});
    t_scan(SC_UP_I, 4'hD, '{13, 14, 15});
    go(rw(SEL_LS0, 11'h081));
    go(rw(SEL_LS1, 11'h005));
    t_scan(SC_LST_I, 4'h0, '{0, 2, 8, 15});
    t_avg;
    t_ovf;
    t_rstall;
    t_man;
    conclude;
  end
endmodule // test_adc_scan_sequencer_control
